// [hdl/ldcr_top.sv]
// Configuration registers, I2C target and dimming/boost control logic.
// Assumes SDA/SCL/PWM and the analog comparator trips are asynchronous pins.
`timescale 1ns/100ps
module ldcr_top #(
  parameter int unsigned DIM_TIMEOUT = ldcr_pkg::DIM_TIMEOUT_CYC
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic pwm_in,
  input wire logic ocp_trip_in,
  input wire logic ovp_trip_in,
  input wire logic [7:0] reg_brightness_in,
  output logic sda_out_out,
  output logic sda_oe_n_out,
  output logic sink_en_out,
  output logic [7:0] amplitude_out,
  output logic [7:0] channel_current_out,
  output ldcr_pkg::ldcr_mode_t dim_mode_out,
  output logic spread_en_out,
  output logic [1:0] edge_rate_out,
  output logic ocp_high_out,
  output logic [1:0] overvoltage_threshold_out,
  output logic [1:0] ldo_sel_out,
  output logic switch_node_drive_out
);
  import ldcr_pkg::*;

  typedef enum logic [3:0] {S_IDLE, S_ADDR, S_ADDR_ACK, S_PTR, S_PTR_ACK,
    S_WDATA, S_WDATA_ACK, S_RDATA, S_RDATA_ACK} ldcr_i2c_t;

  function automatic logic [7:0] thr_level(input logic [1:0] code);
    unique case (code)
      2'b00: thr_level = 8'h00;
      2'b01: thr_level = THR_6P25;
      2'b10: thr_level = THR_12P5;
      2'b11: thr_level = THR_25;
    endcase
  endfunction

  function automatic logic [11:0] boost_period(input logic [3:0] code);
    int unsigned khz;
    khz = BOOST_MID_KHZ + BOOST_STEP_HI_KHZ * 32'(BOOST_TOP_CODE - BOOST_MID_CODE);
    if (code <= BOOST_MID_CODE)
      khz = BOOST_BASE_KHZ + BOOST_STEP_LO_KHZ * 32'(code);
    else if (code <= BOOST_TOP_CODE)
      khz = BOOST_MID_KHZ + BOOST_STEP_HI_KHZ * 32'(code - BOOST_MID_CODE);
    boost_period = 12'((CLK_HZ / 1000) / khz);
  endfunction

  logic [1:0] scl_q_r, sda_q_r, pwm_q_r, ocp_q_r, ovp_q_r;
  logic scl_d_r, sda_d_r;
  logic scl_s, sda_s, pwm_s, ocp_s, ovp_s;
  logic start_c, stop_c, scl_rise, scl_fall;
  ldcr_i2c_t st_r;
  logic [3:0] bitc_r;
  logic [7:0] sh_r, tx_r, ptr_r;
  logic rw_r, wr_r;
  logic [7:0] wr_data_r;
  logic [7:0] dim_ctrl_r, boost_r, cur_r, volt_r;
  logic [7:0] rd_byte;

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      scl_q_r <= 2'b11;
      sda_q_r <= 2'b11;
      pwm_q_r <= 2'b00;
      ocp_q_r <= 2'b00;
      ovp_q_r <= 2'b00;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end
    else
    begin
      scl_q_r <= {scl_q_r[0], scl_in};
      sda_q_r <= {sda_q_r[0], sda_in};
      pwm_q_r <= {pwm_q_r[0], pwm_in};
      ocp_q_r <= {ocp_q_r[0], ocp_trip_in};
      ovp_q_r <= {ovp_q_r[0], ovp_trip_in};
      scl_d_r <= scl_q_r[1];
      sda_d_r <= sda_q_r[1];
    end
  end

  assign scl_s = scl_q_r[1];
  assign sda_s = sda_q_r[1];
  assign pwm_s = pwm_q_r[1];
  assign ocp_s = ocp_q_r[1];
  assign ovp_s = ovp_q_r[1];
  assign start_c = scl_s && scl_d_r && sda_d_r && !sda_s;
  assign stop_c = scl_s && scl_d_r && !sda_d_r && sda_s;
  assign scl_rise = scl_s && !scl_d_r;
  assign scl_fall = !scl_s && scl_d_r;

  // ****************************************************************
  // I2C target: address, register pointer, then data with auto-increment.
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      st_r <= S_IDLE;
      bitc_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      wr_r <= 1'b0;
      wr_data_r <= 8'h00;
      sda_oe_n_out <= 1'b1;
      sda_out_out <= 1'b0;
    end
    else
    begin
      wr_r <= 1'b0;
      sda_out_out <= 1'b0;
      if (start_c)
      begin
        st_r <= S_ADDR;
        bitc_r <= 4'h0;
        sda_oe_n_out <= 1'b1;
      end
      else if (stop_c)
      begin
        st_r <= S_IDLE;
        sda_oe_n_out <= 1'b1;
      end
      else if (scl_rise)
      begin
        if (st_r == S_RDATA_ACK && sda_s)
          st_r <= S_IDLE;
        else if (st_r == S_ADDR || st_r == S_PTR || st_r == S_WDATA || st_r == S_RDATA)
        begin
          sh_r <= {sh_r[6:0], sda_s};
          bitc_r <= bitc_r + 4'h1;
        end
      end
      else if (scl_fall)
      begin
        unique case (st_r)
          S_IDLE: sda_oe_n_out <= 1'b1;
          S_ADDR:
            if (bitc_r == 4'h8)
            begin
              if (sh_r[7:1] == TARGET_ADDR)
              begin
                st_r <= S_ADDR_ACK;
                rw_r <= sh_r[0];
                sda_oe_n_out <= 1'b0;
              end
              else
                st_r <= S_IDLE;
            end
          S_ADDR_ACK:
          begin
            bitc_r <= 4'h0;
            if (rw_r)
            begin
              st_r <= S_RDATA;
              tx_r <= {rd_byte[6:0], 1'b0};
              sda_oe_n_out <= rd_byte[7];
            end
            else
            begin
              st_r <= S_PTR;
              sda_oe_n_out <= 1'b1;
            end
          end
          S_PTR:
            if (bitc_r == 4'h8)
            begin
              ptr_r <= sh_r;
              st_r <= S_PTR_ACK;
              sda_oe_n_out <= 1'b0;
            end
          S_WDATA:
            if (bitc_r == 4'h8)
            begin
              wr_r <= 1'b1;
              wr_data_r <= sh_r;
              st_r <= S_WDATA_ACK;
              sda_oe_n_out <= 1'b0;
            end
          S_PTR_ACK, S_WDATA_ACK:
          begin
            if (st_r == S_WDATA_ACK)
              ptr_r <= ptr_r + 8'h1;
            st_r <= S_WDATA;
            bitc_r <= 4'h0;
            sda_oe_n_out <= 1'b1;
          end
          S_RDATA:
            if (bitc_r == 4'h8)
            begin
              st_r <= S_RDATA_ACK;
              ptr_r <= ptr_r + 8'h1;
              sda_oe_n_out <= 1'b1;
            end
            else
            begin
              tx_r <= {tx_r[6:0], 1'b0};
              sda_oe_n_out <= tx_r[7];
            end
          S_RDATA_ACK:
          begin
            st_r <= S_RDATA;
            bitc_r <= 4'h0;
            tx_r <= {rd_byte[6:0], 1'b0};
            sda_oe_n_out <= rd_byte[7];
          end
        endcase
      end
    end
  end

  function automatic logic [7:0] reg_read(input logic [7:0] ofs);
    unique case (ofs)
      OFS_DIM_SW_CTRL: reg_read = dim_ctrl_r;
      OFS_BOOST_PROT: reg_read = boost_r;
      OFS_CH_CURRENT: reg_read = cur_r;
      OFS_REG_VOLT: reg_read = volt_r;
      default: reg_read = 8'h00;
    endcase
  endfunction

  assign rd_byte = reg_read(ptr_r);

  // ****************************************************************
  // Register file; writes to other offsets are acknowledged and dropped.
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      dim_ctrl_r <= RST_DIM_SW_CTRL;
      boost_r <= RST_BOOST_PROT;
      cur_r <= RST_CH_CURRENT;
      volt_r <= RST_REG_VOLT;
    end
    else if (wr_r)
    begin
      if (ptr_r == OFS_DIM_SW_CTRL)
        dim_ctrl_r <= wr_data_r;
      if (ptr_r == OFS_BOOST_PROT)
        boost_r <= wr_data_r;
      if (ptr_r == OFS_CH_CURRENT)
        cur_r <= wr_data_r;
      if (ptr_r == OFS_REG_VOLT)
        volt_r <= wr_data_r;
    end
  end

  // ****************************************************************
  // Static configuration outputs.
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      spread_en_out <= 1'b0;
      edge_rate_out <= 2'b00;
      ocp_high_out <= 1'b0;
      overvoltage_threshold_out <= 2'b00;
      ldo_sel_out <= 2'b00;
      channel_current_out <= 8'h00;
    end
    else
    begin
      spread_en_out <= dim_ctrl_r[BIT_SPREAD];
      edge_rate_out <= dim_ctrl_r[POS_EDGE +: 2];
      ocp_high_out <= boost_r[BIT_OCP_HIGH];
      overvoltage_threshold_out <= boost_r[POS_OVP +: 2];
      ldo_sel_out <= volt_r[POS_LDO +: 2];
      channel_current_out <= cur_r;
    end
  end

  // ****************************************************************
  // Dimming signal: pin waveform or an internal 26 kHz generator.
  // ****************************************************************
  logic pin_done;
  logic [7:0] pin_duty;
  logic [10:0] fix_cnt_r;
  logic fix_sig, fixed_rate, src_regs;
  logic [7:0] src_duty, thr;
  logic dsig, dper_done;
  logic [7:0] dly1_r, dly2_r;
  logic [8:0] avg;
  ldcr_mode_t mode;

  ldcr_duty_meter #(.TIMEOUT_CYC(DIM_TIMEOUT)) u_meter (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .pwm_in(pwm_s),
    .period_done_out(pin_done),
    .duty_out(pin_duty)
  );

  assign fixed_rate = dim_ctrl_r[BIT_FIXED_RATE];
  assign src_regs = dim_ctrl_r[BIT_SRC_REGS];
  assign src_duty = src_regs ? reg_brightness_in : pin_duty;
  assign fix_sig = {fix_cnt_r, 1'b0} < 12'({4'h0, src_duty} * 12'hf);
  assign dsig = (fixed_rate || src_regs) ? fix_sig : pwm_s;
  assign dper_done = (fixed_rate || src_regs) ? (fix_cnt_r == 11'h0) : pin_done;
  assign thr = thr_level(dim_ctrl_r[POS_THR +: 2]);
  assign avg = {1'b0, dly1_r} + {1'b0, dly2_r};

  always_comb
  begin
    if (!dim_ctrl_r[BIT_MODE_MIXED])
      mode = LDCR_PWM;
    else if (dim_ctrl_r[POS_THR +: 2] == 2'b00)
      mode = LDCR_DC;
    else
      mode = LDCR_MIXED;
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in || fix_cnt_r == FIXED_DIM_CYC - 11'h1)
      fix_cnt_r <= 11'h0;
    else
      fix_cnt_r <= fix_cnt_r + 11'h1;
  end

  // Two-period history of the duty feeds the averaged amplitude.
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      dly1_r <= 8'h00;
      dly2_r <= 8'h00;
    end
    else if (dper_done)
    begin
      dly1_r <= src_duty;
      dly2_r <= dly1_r;
    end
  end

  // ****************************************************************
  // Current sink enable and amplitude.
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      sink_en_out <= 1'b0;
      amplitude_out <= 8'h00;
      dim_mode_out <= LDCR_PWM;
    end
    else
    begin
      dim_mode_out <= mode;
      if (cur_r == 8'h00)
      begin
        sink_en_out <= 1'b0;
        amplitude_out <= 8'h00;
      end
      else if (mode == LDCR_PWM)
      begin
        sink_en_out <= dsig;
        amplitude_out <= DUTY_FULL;
      end
      else if (mode == LDCR_DC || dly2_r >= thr)
      begin
        sink_en_out <= 1'b1;
        amplitude_out <= avg[8:1];
      end
      else
      begin
        sink_en_out <= dsig;
        amplitude_out <= thr;
      end
    end
  end

  // ****************************************************************
  // Boost oscillator and switch with current and voltage protection.
  // ****************************************************************
  logic [11:0] osc_cnt_r;
  logic osc_start;

  assign osc_start = osc_cnt_r == 12'h0;

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in || osc_cnt_r >= boost_period(boost_r[POS_BOOST_FREQ +: 4]) - 12'h1)
      osc_cnt_r <= 12'h0;
    else
      osc_cnt_r <= osc_cnt_r + 12'h1;
  end

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      switch_node_drive_out <= 1'b0;
    else if (ovp_s || ocp_s)
      switch_node_drive_out <= 1'b0;
    else if (osc_start)
      switch_node_drive_out <= 1'b1;
  end

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  sequence s_trip;
    ocp_s || ovp_s;
  endsequence
  sequence s_off_until_osc;
    !switch_node_drive_out [*1] ##0 !osc_start;
  endsequence

  a_ocp_switch_off: assert property (ocp_s |=> !switch_node_drive_out)
    else $error("switch stayed on after current trip");
  a_off_until_osc: assert property (s_trip
    ##1 ((!ocp_s && !ovp_s) ##0 s_off_until_osc) |=> !switch_node_drive_out)
    else $error("switch turned on without an oscillator start");
  a_ovp_hold_off: assert property (ovp_s [*2] |=> !switch_node_drive_out)
    else $error("switch on during overvoltage");
  a_zero_current: assert property (cur_r == 8'h00
    |=> !sink_en_out && amplitude_out == 8'h00)
    else $error("current flows with zero setting");
  a_pwm_follow: assert property (mode == LDCR_PWM && cur_r != 8'h00
    |=> sink_en_out == $past(dsig))
    else $error("sinks not following dimming signal");
  a_dc_mode_sel: assert property (dim_ctrl_r[BIT_MODE_MIXED]
    && dim_ctrl_r[POS_THR +: 2] == 2'b00 |=> dim_mode_out == LDCR_DC)
    else $error("DC dimming not selected");
  a_mixed_quarter: assert property (mode == LDCR_MIXED && thr == THR_25
    && dly2_r < THR_25 && cur_r != 8'h00 |=> amplitude_out == THR_25)
    else $error("mixed low duty amplitude not a quarter");
  a_dc_delay: assert property (mode == LDCR_DC && cur_r != 8'h00 && dper_done
    ##1 !dper_done
    |=> amplitude_out == 8'(({1'b0, $past(dly1_r)} + {1'b0, $past(dly2_r)}) >> 1))
    else $error("DC amplitude not the two-period average");
  a_write_applies: assert property (wr_r && ptr_r == OFS_CH_CURRENT
    |=> ##1 channel_current_out == $past(wr_data_r, 2))
    else $error("written current not applied");
  a_ack_addr: assert property (st_r == S_ADDR && scl_fall && bitc_r == 4'h8
    && sh_r[7:1] == TARGET_ADDR |=> !sda_oe_n_out)
    else $error("own address not acknowledged");
endmodule

// [common/ldcr_pkg.sv]
// Constants shared by the LED dimming configuration block.
// Assumes a single 50 MHz clock and a synchronous active-low reset.
package ldcr_pkg;
  // ****************************************************************
  // Clock and timing
  // ****************************************************************
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned FIXED_DIM_HZ = 26_000;
  localparam logic [10:0] FIXED_DIM_CYC = 11'(CLK_HZ / FIXED_DIM_HZ);
  localparam int unsigned DIM_TIMEOUT_MS = 20;
  localparam int unsigned DIM_TIMEOUT_CYC = CLK_HZ / 1000 * DIM_TIMEOUT_MS;
  localparam int unsigned BOOST_BASE_KHZ = 300;
  localparam int unsigned BOOST_STEP_LO_KHZ = 100;
  localparam int unsigned BOOST_MID_KHZ = 1000;
  localparam int unsigned BOOST_STEP_HI_KHZ = 200;
  localparam logic [3:0] BOOST_MID_CODE = 4'h7;
  localparam logic [3:0] BOOST_TOP_CODE = 4'hc;
  // ****************************************************************
  // Target address and register offsets
  // ****************************************************************
  localparam logic [6:0] TARGET_ADDR = 7'h31;
  localparam logic [7:0] OFS_DIM_SW_CTRL = 8'h00;
  localparam logic [7:0] OFS_BOOST_PROT = 8'h01;
  localparam logic [7:0] OFS_CH_CURRENT = 8'h02;
  localparam logic [7:0] OFS_REG_VOLT = 8'h03;
  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] RST_DIM_SW_CTRL = 8'h4c;
  localparam logic [7:0] RST_BOOST_PROT = 8'h76;
  localparam logic [7:0] RST_CH_CURRENT = 8'h92;
  localparam logic [7:0] RST_REG_VOLT = 8'h00;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned BIT_MODE_MIXED = 0;
  localparam int unsigned BIT_SRC_REGS = 1;
  localparam int unsigned POS_THR = 2;
  localparam int unsigned BIT_SPREAD = 4;
  localparam int unsigned POS_EDGE = 5;
  localparam int unsigned BIT_FIXED_RATE = 7;
  localparam int unsigned POS_BOOST_FREQ = 0;
  localparam int unsigned BIT_OCP_HIGH = 4;
  localparam int unsigned POS_OVP = 5;
  localparam int unsigned POS_LDO = 5;
  // ****************************************************************
  // Duty levels on a 0..255 scale
  // ****************************************************************
  localparam logic [7:0] DUTY_FULL = 8'hff;
  localparam logic [7:0] THR_6P25 = 8'h10;
  localparam logic [7:0] THR_12P5 = 8'h20;
  localparam logic [7:0] THR_25 = 8'h40;
  typedef enum logic [1:0] {LDCR_PWM, LDCR_DC, LDCR_MIXED} ldcr_mode_t;
endpackage

// [hdl/ldcr_duty_meter.sv]
// Measures the duty of a synchronised dimming waveform once per period.
// Assumes the input is already on the clk_in domain.
`timescale 1ns/100ps
module ldcr_duty_meter #(
  parameter int unsigned TIMEOUT_CYC = 1_000_000
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic pwm_in,
  output logic period_done_out,
  output logic [7:0] duty_out
);
  import ldcr_pkg::*;

  logic pwm_d_r;
  logic [20:0] total_r;
  logic [20:0] high_r;
  logic [20:0] div_tot_r;
  logic [20:0] rem_r;
  logic [7:0] quo_r;
  logic [3:0] step_r;
  logic rise;
  logic timeout;
  logic [20:0] rem_sh;

  assign rise = pwm_in && !pwm_d_r;
  assign timeout = total_r >= 21'(TIMEOUT_CYC);
  assign rem_sh = {rem_r[19:0], 1'b0};

  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
      pwm_d_r <= 1'b0;
    else
      pwm_d_r <= pwm_in;
  end

  // ****************************************************************
  // Period and high-time counters, restarted at each rising edge.
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in || rise || timeout)
    begin
      total_r <= 21'h1;
      high_r <= {20'h0, pwm_in};
    end
    else
    begin
      total_r <= total_r + 21'h1;
      high_r <= high_r + {20'h0, pwm_in};
    end
  end

  // ****************************************************************
  // Serial divider: duty = high * 256 / total, one bit per cycle.
  // A stalled pin reports 0 or full duty after the timeout.
  // ****************************************************************
  always_ff @(posedge clk_in)
  begin
    if (!nrst_in)
    begin
      step_r <= 4'h0;
      rem_r <= 21'h0;
      div_tot_r <= 21'h1;
      quo_r <= 8'h0;
      duty_out <= 8'h0;
      period_done_out <= 1'b0;
    end
    else
    begin
      period_done_out <= 1'b0;
      if (timeout)
      begin
        step_r <= 4'h0;
        duty_out <= pwm_in ? DUTY_FULL : 8'h0;
        period_done_out <= 1'b1;
      end
      else if (rise && total_r > 21'h1)
      begin
        step_r <= 4'h8;
        rem_r <= high_r;
        div_tot_r <= total_r;
        quo_r <= 8'h0;
      end
      else if (step_r != 4'h0)
      begin
        step_r <= step_r - 4'h1;
        if (rem_sh >= div_tot_r)
        begin
          rem_r <= rem_sh - div_tot_r;
          quo_r <= {quo_r[6:0], 1'b1};
        end
        else
        begin
          rem_r <= rem_sh;
          quo_r <= {quo_r[6:0], 1'b0};
        end
        if (step_r == 4'h1)
        begin
          duty_out <= (rem_sh >= div_tot_r) ? {quo_r[6:0], 1'b1} : {quo_r[6:0], 1'b0};
          period_done_out <= 1'b1;
        end
      end
    end
  end
endmodule

// [dv/ldcr_partner.sv]
// Host model: I2C controller and PWM dimming source for ldcr_top.
// Assumes the bench resolves the SDA wire and feeds it back on sda_in.
`timescale 1ns/100ps
module ldcr_partner (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_low_out,
  output logic pwm_out
);
  import ldcr_pkg::*;
  logic acked = 1'b1;
  initial {scl_out, sda_low_out, pwm_out} = 3'b100;
  task automatic tk(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // SCL and SDA move five clocks apart, so SCL low lasts ten clocks and SCL high at least ten (twelve between the bits of xf).
  task automatic cd(input logic a, input logic b, input logic e, input logic f);
    tk(5);
    scl_out <= a;
    tk(5);
    sda_low_out <= !b;
    tk(5);
    scl_out <= e;
    tk(5);
    sda_low_out <= !f;
  endtask
  // An all-ones byte is read data, so a released ack bit after it is not counted as a missing ack.
  task automatic xf(input logic [7:0] tx, output logic [7:0] rx);
    logic b;
    for (int i = 8; i >= 0; i--)
    begin
      b = (i > 0) ? tx[i - 1] : 1'b1;
      cd(1'b0, b, 1'b1, b);
      tk(2);
      if (i > 0)
        rx[i - 1] = sda_in;
      else if (sda_in && tx != 8'hff)
        acked = 1'b0;
    end
  endtask
  task automatic xs(input logic rd, input logic [7:0] ofs, input logic [7:0] v,
    output logic [7:0] q);
    cd(1'b0, 1'b1, 1'b1, 1'b0);
    xf({TARGET_ADDR, 1'b0}, q);
    xf(ofs, q);
    if (rd)
    begin
      cd(1'b0, 1'b1, 1'b1, 1'b0);
      xf({TARGET_ADDR, 1'b1}, q);
      xf(8'hff, q);
    end
    else
      xf(v, q);
    cd(1'b0, 1'b0, 1'b1, 1'b1);
  endtask
  task automatic pw(input logic v, input int n);
    @(posedge clk_in);
    pwm_out <= v;
    tk(n);
  endtask
endmodule

// [dv/ldcr_top_tb.sv]
// Bench for ldcr_top: I2C and PWM come from the partner, trips from here.
// Assumes ldcr_pkg and ldcr_partner are compiled before this file.
`timescale 1ns/100ps
module ldcr_top_tb;
  import ldcr_pkg::*;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic ocp_trip_in = 1'b0;
  logic ovp_trip_in = 1'b0;
  logic scl, sda_low, pwm, sda_oe_n, sink, sw, spread, ocp_hi, sdo;
  logic [7:0] amp, cur, rv;
  logic [7:0] bri = 8'h80;
  logic [1:0] edge_r, ovp_thr, ldo;
  ldcr_mode_t mode;
  wire sda = !sda_low && sda_oe_n;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;
  ldcr_partner partner_u (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
    .sda_low_out(sda_low), .pwm_out(pwm));
  ldcr_top #(.DIM_TIMEOUT(400)) dut_u (.clk_in(clk_in), .nrst_in(nrst_in), .scl_in(scl),
    .sda_in(sda), .pwm_in(pwm), .ocp_trip_in(ocp_trip_in), .ovp_trip_in(ovp_trip_in),
    .reg_brightness_in(bri), .sda_out_out(sdo), .sda_oe_n_out(sda_oe_n),
    .sink_en_out(sink), .amplitude_out(amp), .channel_current_out(cur),
    .dim_mode_out(mode), .spread_en_out(spread), .edge_rate_out(edge_r),
    .ocp_high_out(ocp_hi), .overvoltage_threshold_out(ovp_thr), .ldo_sel_out(ldo),
    .switch_node_drive_out(sw));
  always #10 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_mismatch = n_mismatch + 1;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] ofs, input logic [7:0] v);
    partner_u.xs(1'b0, ofs, v, rv);
  endtask
  // Offset 4 lies outside the bank and must read back as zero.
  task automatic t_reset();
    logic [7:0] dflt [5] = '{8'h4c, 8'h76, 8'h92, 8'h00, 8'h00};
    for (int i = 0; i < 5; i++)
    begin
      partner_u.xs(1'b1, 8'(i), 8'h00, rv);
      chk("reset read", rv, dflt[i]);
    end
    chk("mode", mode, LDCR_PWM);
    chk("edge", edge_r, 8'h02);
    chk("spread", spread, 8'h00);
    chk("limit", ocp_hi, 8'h01);
    chk("ovp", ovp_thr, 8'h03);
    chk("ldo", ldo, 8'h00);
    chk("current", cur, 8'h92);
    chk("sda out", sdo, 8'h00);
  endtask
  task automatic t_fields();
    wr(8'h00, 8'h31);
    chk("dc mode", mode, LDCR_DC);
    chk("spread on", spread, 8'h01);
    chk("edge", edge_r, 8'h01);
    wr(8'h01, 8'h2c);
    chk("ovp", ovp_thr, 8'h01);
    chk("limit", ocp_hi, 8'h00);
    wr(8'h03, 8'h60);
    chk("ldo", ldo, 8'h03);
    wr(8'h02, 8'h00);
    chk("zero current", cur, 8'h00);
    chk("zero sink", sink, 8'h00);
    chk("zero amp", amp, 8'h00);
    wr(8'h02, 8'hfe);
    chk("current", cur, 8'hfe);
    partner_u.xs(1'b1, 8'h01, 8'h00, rv);
    chk("readback", rv, 8'h2c);
  endtask
  // Four pin periods of 200 clocks, hi clocks high in each.
  task automatic run(input logic [7:0] ctl, input int hi);
    wr(8'h00, ctl);
    repeat (4)
    begin
      partner_u.pw(1'b1, hi - 1);
      partner_u.pw(1'b0, 199 - hi);
    end
  endtask
  task automatic t_dim();
    wr(8'h00, 8'h4c);
    chk("pwm mode", mode, LDCR_PWM);
    partner_u.pw(1'b1, 6);
    chk("sink high", sink, 8'h01);
    partner_u.pw(1'b0, 6);
    chk("sink low", sink, 8'h00);
    run(8'h4d, 25);
    chk("mixed mode", mode, LDCR_MIXED);
    chk("quarter", amp, 8'h40);
    run(8'h4d, 100);
    chk("mixed amp", 8'(amp > 8'h7a && amp < 8'h86), 8'h01);
    chk("mixed sink", sink, 8'h01);
    run(8'h41, 100);
    chk("dc mode", mode, LDCR_DC);
    chk("dc amp", 8'(amp > 8'h7a && amp < 8'h86), 8'h01);
    chk("dc sink", sink, 8'h01);
  endtask
  // Measures one period of the sinks from rise to rise, and its high cycles.
  task automatic meas(output int per, output int hc);
    logic prv;
    per = 0;
    hc = 0;
    prv = 1'b1;
    while (sink !== 1'b0) @(posedge clk_in);
    while (sink !== 1'b1) @(posedge clk_in);
    do
    begin
      hc = hc + ((sink === 1'b1) ? 1 : 0);
      prv = sink;
      @(posedge clk_in);
      per = per + 1;
    end
    while (!(sink === 1'b1 && prv === 1'b0) && per < 4000);
  endtask
  // Internal 26 kHz rate: register duty first, then a held-high pin at fixed rate.
  task automatic t_rate();
    int per;
    int hc;
    bri <= 8'h40;
    wr(8'h00, 8'h4e);
    meas(per, hc);
    chk("reg period", 8'(per == FIXED_DIM_CYC), 8'h01);
    chk("reg duty", 8'(hc > 470 && hc < 491), 8'h01);
    partner_u.pw(1'b1, 1);
    wr(8'h00, 8'hcc);
    meas(per, hc);
    chk("fixed period", 8'(per == FIXED_DIM_CYC), 8'h01);
    chk("fixed duty", 8'(hc > 1905 && hc < 1926), 8'h01);
    partner_u.pw(1'b0, 1);
  endtask
  // Boost code 0xc leaves a 25-clock oscillator period.
  task automatic t_boost();
    int t;
    logic ok;
    ok = 1'b1;
    ovp_trip_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    repeat (60) @(posedge clk_in) ok = ok & ~sw;
    chk("ovp hold", ok, 8'h01);
    ovp_trip_in <= 1'b0;
    for (t = 0; sw !== 1'b1 && t < 99; t++) @(posedge clk_in);
    ocp_trip_in <= 1'b1;
    @(posedge clk_in);
    ocp_trip_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    chk("ocp off", sw, 8'h00);
    for (t = 5; sw !== 1'b1 && t < 99; t++) @(posedge clk_in);
    chk("period", 8'(t), 8'h19);
  endtask
  initial
  begin
    repeat (10) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    t_reset();
    t_fields();
    t_dim();
    t_rate();
    t_boost();
    chk("acks", partner_u.acked, 8'h01);
    test_done();
  end
endmodule
